// file: inc/ssam_pkg.sv
// Package: register map, field layout, timing and carriers of the slave address unit
package ssam_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MODE     = 8'h00;
  localparam logic [7:0] REG_OWN_ADDR = 8'h04;
  localparam logic [7:0] REG_SHIFT    = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam logic [7:0] REG_INT_STAT = 8'h10;
  localparam logic [7:0] REG_INT_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_SEL_LO   = 0;
  localparam int MODE_SEL_HI   = 1;
  localparam int MODE_MASTER   = 2;
  localparam int MODE_ENABLE   = 3;
  localparam int MODE_LSB_MASK = 4;
  localparam int MODE_WAKEUP   = 5;
  localparam int ST_MATCH      = 0;
  localparam int ST_RELEASE    = 1;
  localparam int ST_BUSY       = 2;
  localparam int ST_SELECTED   = 3;
  localparam int INT_XFER      = 0;
  localparam int INT_ERR       = 1;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST     = 8'h00;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] SHIFT_RST    = 8'h00;
  localparam logic [7:0] INT_MASK_RST = 8'h00;
  localparam logic [7:0] ALL_ONES     = 8'hFF;
  localparam logic [3:0] BIT_LAST     = 4'h7;

  // ----------------------------------------------------------------
  // Master serial clock timing
  // ----------------------------------------------------------------
  localparam int         SYS_CLK_MHZ     = 40;
  localparam int         MASTER_HALF_NS  = 2000;
  localparam int         MASTER_HALF_CYC = (MASTER_HALF_NS * SYS_CLK_MHZ) / 1000;
  localparam logic [7:0] MASTER_HALF_CNT = 8'(MASTER_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSAM_THREE_WIRE,
    SSAM_PROP_BUS,
    SSAM_TWO_WIRE,
    SSAM_I2C
  } ssam_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssam_req_t;

endpackage

// file: src/ssam_sync.sv
// Two-flop synchronisers for the serial pins
`timescale 1ns/100ps
module ssam_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Asynchronous levels and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Lines idle high, so reset to one to avoid a false edge on release
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        stage1[i]   <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        stage1[i]   <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  end

endmodule // ssam_sync

// file: src/ssam_addr_cmp.sv
// Address comparator with optional low-bit mask
`timescale 1ns/100ps
module ssam_addr_cmp (
  // Compared values
  input  wire logic [7:0] received_in,
  input  wire logic [7:0] own_in,
  // Ignore the least significant bit when set
  input  wire logic       mask_lsb_in,
  // Result
  output logic            match_out
);

  always_comb begin
    if (mask_lsb_in) begin
      match_out = (received_in[7:1] == own_in[7:1]);
    end else begin
      match_out = (received_in == own_in);
    end
  end

endmodule // ssam_addr_cmp

// file: src/ssam_slave_address_match.sv
// Serial interface slave address matching, mode selection and error detection
`timescale 1ns/100ps

module ssam_slave_address_match (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  // Register port
  input  wire ssam_pkg::ssam_req_t reg_req_in,
  output logic [7:0]               reg_rdata_out,
  // Serial clock pin
  input  wire logic                three_wire_clock_pin_in,
  output logic                     three_wire_clock_pin_out,
  output logic                     three_wire_clock_pin_oe_n_out,
  // Separate data pins of 3-wire mode
  input  wire logic                three_wire_data_in_pin_in,
  output logic                     three_wire_data_out_pin_out,
  // Shared open-drain data pin
  input  wire logic                shared_data_pin_in,
  output logic                     shared_data_pin_out,
  output logic                     shared_data_pin_oe_n_out,
  // Interrupt
  output logic                     irq_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]           mode_reg;
  logic [7:0]           own_slave_address;
  logic [7:0]           preset_shift_register;
  logic [7:0]           int_stat;
  logic [7:0]           int_mask;
  logic [7:0]           status;
  logic [7:0]           next_int_ev;
  logic [7:0]           int_clr;
  ssam_pkg::ssam_mode_t mode;
  logic                 enable;
  logic                 master;
  logic                 address_lsb_mask;
  logic                 wakeup_on_match;
  logic                 bus_mode;
  logic                 proprietary_bus_mode;
  logic [2:0]           sync_q;
  logic                 s_clk;
  logic                 s_sda;
  logic                 s_din;
  logic                 p_clk;
  logic                 p_sda;
  logic [7:0]           div_cnt;
  logic                 mclk;
  logic                 master_busy;
  logic                 tick;
  logic                 rise_ev;
  logic                 fall_ev;
  logic                 cond_ok;
  logic                 start_ev;
  logic                 stop_ev;
  logic [3:0]           bit_cnt;
  logic                 byte_done;
  logic                 addr_phase;
  logic                 addr_done;
  logic                 rx_bit;
  logic                 out_bit;
  logic                 drive_low;
  logic                 tx_owned;
  logic                 quiet;
  logic                 match;
  logic                 address_match_flag;
  logic                 release_detect_flag;
  logic                 selected;
  logic                 xfer_ev;
  logic                 arb_err;
  logic                 frame_err;
  logic                 err_ev;

  // Write strobe aimed at one register
  function automatic logic wr_hit(input logic [7:0] offset);
    return reg_req_in.wr && (reg_req_in.addr == offset);
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_reg <= ssam_pkg::MODE_RST;
    end else if (wr_hit(ssam_pkg::REG_MODE)) begin
      mode_reg <= reg_req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      own_slave_address <= ssam_pkg::OWN_ADDR_RST;
    end else if (wr_hit(ssam_pkg::REG_OWN_ADDR)) begin
      own_slave_address <= reg_req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_mask <= ssam_pkg::INT_MASK_RST;
    end else if (wr_hit(ssam_pkg::REG_INT_MASK)) begin
      int_mask <= reg_req_in.wdata;
    end
  end

  assign mode = ssam_pkg::ssam_mode_t'(mode_reg[ssam_pkg::MODE_SEL_HI:ssam_pkg::MODE_SEL_LO]);
  assign enable               = mode_reg[ssam_pkg::MODE_ENABLE];
  assign master               = mode_reg[ssam_pkg::MODE_MASTER];
  assign address_lsb_mask     = mode_reg[ssam_pkg::MODE_LSB_MASK];
  assign wakeup_on_match      = mode_reg[ssam_pkg::MODE_WAKEUP];
  assign bus_mode             = (mode != ssam_pkg::SSAM_THREE_WIRE);
  assign proprietary_bus_mode = (mode == ssam_pkg::SSAM_PROP_BUS);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  ssam_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({three_wire_data_in_pin_in, shared_data_pin_in, three_wire_clock_pin_in}),
    .sync_out (sync_q)
  );

  assign s_clk = sync_q[0];
  assign s_sda = sync_q[1];
  assign s_din = sync_q[2];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      p_clk <= 1'b1;
      p_sda <= 1'b1;
    end else begin
      p_clk <= s_clk;
      p_sda <= s_sda;
    end
  end

  // ----------------------------------------------------------------
  // Master clock generator
  // ----------------------------------------------------------------
  // Clock idles high between transfers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt <= 8'h00;
      mclk    <= 1'b1;
    end else if (!(master && master_busy)) begin
      div_cnt <= 8'h00;
      mclk    <= 1'b1;
    end else if (div_cnt == ssam_pkg::MASTER_HALF_CNT) begin
      div_cnt <= 8'h00;
      mclk    <= ~mclk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign tick = master && master_busy && (div_cnt == ssam_pkg::MASTER_HALF_CNT);

  assign rise_ev = enable && (master ? (tick && !mclk) : (s_clk && !p_clk));
  assign fall_ev = enable && (master ? (tick && mclk) : (!s_clk && p_clk));

  // clock pin driven only as master
  assign three_wire_clock_pin_out      = mclk;
  assign three_wire_clock_pin_oe_n_out = !(enable && master);

  // ----------------------------------------------------------------
  // Start and stop conditions
  // ----------------------------------------------------------------
  // Data moves while the clock stays high
  assign cond_ok  = enable && bus_mode && !master && s_clk && p_clk;
  assign start_ev = cond_ok && p_sda && !s_sda;
  assign stop_ev  = cond_ok && !p_sda && s_sda;

  // ----------------------------------------------------------------
  // Bit counting and address phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt   <= 4'h0;
      byte_done <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (start_ev || stop_ev || !enable) begin
        bit_cnt <= 4'h0;
      end else if (rise_ev) begin
        if (bit_cnt == ssam_pkg::BIT_LAST) begin
          bit_cnt   <= 4'h0;
          byte_done <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_phase <= 1'b0;
    end else if (start_ev) begin
      addr_phase <= 1'b1;
    end else if (byte_done || stop_ev || !enable) begin
      addr_phase <= 1'b0;
    end
  end

  assign addr_done = byte_done && addr_phase;

  // ----------------------------------------------------------------
  // Shift register and data pins
  // ----------------------------------------------------------------
  // data pin choice
  assign rx_bit = bus_mode ? s_sda : s_din;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      preset_shift_register <= ssam_pkg::SHIFT_RST;
    end else if (wr_hit(ssam_pkg::REG_SHIFT)) begin
      preset_shift_register <= reg_req_in.wdata;
    end else if (start_ev && proprietary_bus_mode && !wakeup_on_match) begin
      preset_shift_register <= ssam_pkg::ALL_ONES;
    end else if (rise_ev) begin
      preset_shift_register <= {preset_shift_register[6:0], rx_bit};
    end
  end

  // Released during wake-up address reception so the line is never pulled
  assign quiet = addr_phase && wakeup_on_match && !master;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_bit <= 1'b1;
    end else if (fall_ev) begin
      out_bit <= preset_shift_register[7];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_low <= 1'b0;
    end else if (!enable || !bus_mode || start_ev || stop_ev || byte_done) begin
      drive_low <= 1'b0;
    end else if (fall_ev) begin
      drive_low <= !preset_shift_register[7] && !quiet;
    end
  end

  assign three_wire_data_out_pin_out = out_bit;
  assign shared_data_pin_out         = 1'b0;
  assign shared_data_pin_oe_n_out    = !drive_low;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_owned <= 1'b0;
    end else if (wr_hit(ssam_pkg::REG_SHIFT)) begin
      tx_owned <= 1'b1;
    end else if (byte_done || start_ev || stop_ev) begin
      tx_owned <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      master_busy <= 1'b0;
    end else if (!enable || !master) begin
      master_busy <= 1'b0;
    end else if (wr_hit(ssam_pkg::REG_SHIFT)) begin
      master_busy <= 1'b1;
    end else if (rise_ev && (bit_cnt == ssam_pkg::BIT_LAST)) begin
      master_busy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Address comparison and flags
  // ----------------------------------------------------------------
  // compare received byte
  ssam_addr_cmp u_cmp (
    .received_in (preset_shift_register),
    .own_in      (own_slave_address),
    .mask_lsb_in (address_lsb_mask),
    .match_out   (match)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      address_match_flag <= 1'b0;
    end else begin
      if (start_ev) begin
        address_match_flag <= 1'b0;
      end
      if (addr_done && match) begin
        address_match_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      selected <= 1'b0;
    end else if (stop_ev || !enable) begin
      selected <= 1'b0;
    end else if (addr_done) begin
      selected <= match;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      release_detect_flag <= 1'b0;
    end else begin
      if (addr_done && !match) begin
        release_detect_flag <= 1'b0;
      end
      if (stop_ev) begin
        release_detect_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  // wake-up gating
  assign xfer_ev = wakeup_on_match ? (addr_done && match) : byte_done;

  // released bit read low, or frame cut short
  assign arb_err   = rise_ev && bus_mode && tx_owned && !quiet && out_bit && !rx_bit;
  assign frame_err = (start_ev || stop_ev) && (bit_cnt != 4'h0);
  assign err_ev    = arb_err || frame_err;

  always_comb begin
    next_int_ev                     = 8'h00;
    next_int_ev[ssam_pkg::INT_XFER] = xfer_ev;
    next_int_ev[ssam_pkg::INT_ERR]  = err_ev;
    int_clr = wr_hit(ssam_pkg::REG_INT_STAT) ? reg_req_in.wdata : 8'h00;
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_stat <= 8'h00;
    end else begin
      int_stat <= (int_stat & ~int_clr) | next_int_ev;
    end
  end

  assign irq_out = |(int_stat & int_mask);

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_comb begin
    status                        = 8'h00;
    status[ssam_pkg::ST_MATCH]    = address_match_flag;
    status[ssam_pkg::ST_RELEASE]  = release_detect_flag;
    status[ssam_pkg::ST_BUSY]     = master_busy || (bit_cnt != 4'h0);
    status[ssam_pkg::ST_SELECTED] = selected;
  end

  // Data stand for one cycle only, zero otherwise
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= 8'h00;
      if (reg_req_in.rd) begin
        case (reg_req_in.addr)
          ssam_pkg::REG_MODE: begin
            reg_rdata_out <= mode_reg;
          end
          ssam_pkg::REG_OWN_ADDR: begin
            reg_rdata_out <= own_slave_address;
          end
          ssam_pkg::REG_SHIFT: begin
            reg_rdata_out <= preset_shift_register;
          end
          ssam_pkg::REG_STATUS: begin
            reg_rdata_out <= status;
          end
          ssam_pkg::REG_INT_STAT: begin
            reg_rdata_out <= int_stat;
          end
          ssam_pkg::REG_INT_MASK: begin
            reg_rdata_out <= int_mask;
          end
          default: begin
            reg_rdata_out <= 8'h00;
          end
        endcase
      end
    end
  end

endmodule // ssam_slave_address_match

// file: bench/ssam_checker.sv
// Port-level assertions for the slave address unit
`timescale 1ns/100ps
module ssam_checker (
  // Clock and reset
  input wire logic                clk_in,
  input wire logic                rst_in,
  // Register port
  input wire ssam_pkg::ssam_req_t reg_req_in,
  input wire logic [7:0]          reg_rdata_out,
  // Pins and interrupt
  input wire logic                three_wire_clock_pin_out,
  input wire logic                three_wire_clock_pin_oe_n_out,
  input wire logic                irq_out
);
  logic [7:0] own_sh;
  logic [7:0] mode_sh;
  logic [7:0] mask_sh;
  logic [7:0] low_cnt;
  wire        rd_own  = reg_req_in.rd && reg_req_in.addr == ssam_pkg::REG_OWN_ADDR;
  wire        rd_mode = reg_req_in.rd && reg_req_in.addr == ssam_pkg::REG_MODE;
  wire        rd_ist  = reg_req_in.rd && reg_req_in.addr == ssam_pkg::REG_INT_STAT;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      own_sh  <= ssam_pkg::OWN_ADDR_RST;
      mode_sh <= ssam_pkg::MODE_RST;
      mask_sh <= ssam_pkg::INT_MASK_RST;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == ssam_pkg::REG_OWN_ADDR) own_sh <= reg_req_in.wdata;
      if (reg_req_in.addr == ssam_pkg::REG_MODE) mode_sh <= reg_req_in.wdata;
      if (reg_req_in.addr == ssam_pkg::REG_INT_MASK) mask_sh <= reg_req_in.wdata;
    end
  end
  // Length of the current low phase of the driven clock
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) low_cnt <= 8'h00;
    else low_cnt <= three_wire_clock_pin_out ? 8'h00 : low_cnt + 8'h01;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rdata_idle_zero: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  a_own_addr_readback: assert property (rd_own |=> reg_rdata_out == own_sh)
    else $error("own address readback wrong");
  a_unmapped_read: assert property (reg_req_in.rd && reg_req_in.addr == 8'h1C
    |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_mode_readback: assert property (rd_mode |=> reg_rdata_out[5:0] == mode_sh[5:0])
    else $error("mode readback wrong");
  a_irq_level_match: assert property (rd_ist |=> $past(irq_out) == |(reg_rdata_out & mask_sh))
    else $error("interrupt level disagrees with status and mask");
  a_clk_pin_dir: assert property ($stable(mode_sh) |-> three_wire_clock_pin_oe_n_out ==
    !(mode_sh[ssam_pkg::MODE_ENABLE] && mode_sh[ssam_pkg::MODE_MASTER]))
    else $error("clock pin direction wrong");
  a_clk_idle_high: assert property (three_wire_clock_pin_oe_n_out |-> three_wire_clock_pin_out)
    else $error("clock output not high while released");
  a_half_period: assert property ($rose(three_wire_clock_pin_out)
    |-> low_cnt == 8'(ssam_pkg::MASTER_HALF_CYC)) else $error("master clock low phase wrong");
  c_match_read: cover property (reg_req_in.rd ##1 reg_rdata_out[ssam_pkg::ST_MATCH]);
  c_irq_rise: cover property ($rose(irq_out));
  c_clk_fall: cover property ($fell(three_wire_clock_pin_out));
endmodule // ssam_checker

bind ssam_slave_address_match ssam_checker ssam_checker_i (
  .clk_in                        (clk_in),
  .rst_in                        (rst_in),
  .reg_req_in                    (reg_req_in),
  .reg_rdata_out                 (reg_rdata_out),
  .three_wire_clock_pin_out      (three_wire_clock_pin_out),
  .three_wire_clock_pin_oe_n_out (three_wire_clock_pin_oe_n_out),
  .irq_out                       (irq_out)
);

// file: bench/ssam_bus_partner.sv
// Behavioural serial bus master: clock and open-drain data pull-down
`timescale 1ns/100ps
module ssam_bus_partner (
  // Wired data line level
  input  wire logic sda_in,
  // Driven clock and data pull-down
  output logic      scl_out,
  output logic      sda_low_out
);
  // Clock rests high between frames
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end
  // Data falls while the clock is high
  task automatic start_cond();
    #3 sda_low_out = 1'b0;
    #100 sda_low_out = 1'b1;
    #100;
  endtask
  // Top n bits MSB first, 200 ns per bit, clock left high after the last
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      scl_out = 1'b0;
      #50 sda_low_out = !b[i];
      #50 scl_out = 1'b1;
      #100;
    end
  endtask
  // Data rises while the clock is high
  task automatic stop_cond();
    if (sda_in) begin
      sda_low_out = 1'b1;
      #100;
    end
    sda_low_out = 1'b0;
    #100;
  endtask
endmodule // ssam_bus_partner

// file: bench/tb_ssam_slave_address_match.sv
// Self-checking bench for the slave address unit
`timescale 1ns/100ps
module tb_ssam_slave_address_match;
  logic                clk_in;
  logic                rst_in;
  ssam_pkg::ssam_req_t reg_req_in;
  logic [7:0]          reg_rdata_out;
  logic                clk_o;
  logic                clk_oe_n;
  logic                do_pin;
  logic                sda_o;
  logic                sda_oe_n;
  logic                irq_out;
  logic                p_scl;
  logic                p_low;
  logic [7:0]          own;
  logic [7:0]          rv;
  int                  error_cnt;
  int                  checks;
  // Data line pulled up, any low driver wins; clock taken from the DUT while it drives, else from the partner
  wire scl_w = clk_oe_n ? p_scl : clk_o;
  wire sda_w = !(p_low || (!sda_oe_n && !sda_o));

  ssam_slave_address_match ssam_slave_address_match_i (
    .clk_in (clk_in), .rst_in (rst_in), .reg_req_in (reg_req_in), .reg_rdata_out (reg_rdata_out),
    .three_wire_clock_pin_in (scl_w), .three_wire_clock_pin_out (clk_o),
    .three_wire_clock_pin_oe_n_out (clk_oe_n), .three_wire_data_in_pin_in (sda_w),
    .three_wire_data_out_pin_out (do_pin), .shared_data_pin_in (sda_w),
    .shared_data_pin_out (sda_o), .shared_data_pin_oe_n_out (sda_oe_n), .irq_out (irq_out));
  ssam_bus_partner ssam_bus_partner_i (.sda_in (sda_w), .scl_out (p_scl), .sda_low_out (p_low));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = !clk_in;
  end
  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic exp_match(input logic [7:0] rx, own_a, input logic msk);
    return msk ? rx[7:1] == own_a[7:1] : rx == own_a;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in) reg_req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in) reg_req_in <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in) reg_req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in) reg_req_in <= '0;
    #1 rv = reg_rdata_out;
  endtask
  task automatic addr_byte(input logic [7:0] b);
    ssam_bus_partner_i.start_cond();
    ssam_bus_partner_i.send_bits(b, 8);
    wt(12);
  endtask
  task automatic stop();
    ssam_bus_partner_i.stop_cond();
    wt(12);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    reg_req_in = '0;
    error_cnt = 0;
    checks = 0;
    void'($urandom(32'h750d0fc6));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    wr(ssam_pkg::REG_STATUS, 8'hFF);
    rd(ssam_pkg::REG_MODE);
    chk("mode reset", rv, ssam_pkg::MODE_RST);
    rd(ssam_pkg::REG_OWN_ADDR);
    chk("own reset", rv, ssam_pkg::OWN_ADDR_RST);
    rd(ssam_pkg::REG_STATUS);
    chk("status read-only", rv, 8'h00);
    rd(8'h1C);
    chk("unmapped", rv, 8'h00);
    $display("test reset done");
    for (int m = 1; m < 4; m++) begin
      own = 8'($urandom());
      wr(ssam_pkg::REG_OWN_ADDR, own);
      rd(ssam_pkg::REG_OWN_ADDR);
      chk("own readback", rv, own);
      wr(ssam_pkg::REG_MODE, 8'h28 | 8'(m));
      wr(ssam_pkg::REG_INT_MASK, 8'h01);
      wr(ssam_pkg::REG_INT_STAT, 8'h03);
      addr_byte(own);
      rd(ssam_pkg::REG_STATUS);
      chk("match and selected", rv & 8'h09, 8'h09);
      rd(ssam_pkg::REG_INT_STAT);
      chk("wake irq on match", rv & 8'h01, 8'h01);
      chk("irq line", 8'(irq_out), 8'h01);
      wr(ssam_pkg::REG_INT_STAT, 8'h03);
      chk("irq cleared", 8'(irq_out), 8'h00);
      stop();
      rd(ssam_pkg::REG_STATUS);
      chk("release after stop", rv & 8'h0A, 8'h02);
      addr_byte(own ^ 8'h80);
      rd(ssam_pkg::REG_STATUS);
      chk("mismatch clears", rv & 8'h0B, 8'h00);
      rd(ssam_pkg::REG_INT_STAT);
      chk("no wake irq", rv & 8'h01, 8'h00);
      stop();
    end
    $display("test modes done");
    for (int k = 0; k < 2; k++) begin
      wr(ssam_pkg::REG_MODE, 8'h2B | (k[0] ? 8'h10 : 8'h00));
      addr_byte(own ^ 8'h01);
      rd(ssam_pkg::REG_STATUS);
      chk("lsb mask", 8'(rv[0]), 8'(exp_match(own ^ 8'h01, own, k[0])));
      stop();
    end
    $display("test mask done");
    wr(ssam_pkg::REG_MODE, 8'h09);
    wr(ssam_pkg::REG_INT_STAT, 8'h03);
    ssam_bus_partner_i.start_cond();
    wt(12);
    rd(ssam_pkg::REG_SHIFT);
    chk("preset ones", rv, ssam_pkg::ALL_ONES);
    ssam_bus_partner_i.send_bits(own ^ 8'h80, 8);
    wt(12);
    rd(ssam_pkg::REG_INT_STAT);
    chk("irq every byte", rv & 8'h01, 8'h01);
    stop();
    $display("test preset done");
    wr(ssam_pkg::REG_MODE, 8'h0A);
    wr(ssam_pkg::REG_INT_STAT, 8'h03);
    // Ones keep the shared line released
    wr(ssam_pkg::REG_SHIFT, 8'hFF);
    ssam_bus_partner_i.start_cond();
    ssam_bus_partner_i.send_bits(8'($urandom()), 3);
    stop();
    rd(ssam_pkg::REG_INT_STAT);
    chk("bus error", rv & 8'h02, 8'h02);
    chk("error masked", 8'(irq_out), 8'h00);
    wr(ssam_pkg::REG_INT_MASK, 8'h03);
    chk("error irq", 8'(irq_out), 8'h01);
    wr(ssam_pkg::REG_INT_STAT, 8'h02);
    chk("error cleared", 8'(irq_out), 8'h00);
    $display("test error done");
    wr(ssam_pkg::REG_MODE, 8'h0C);
    wt(2);
    chk("master clock drive", 8'(clk_oe_n), 8'h00);
    own = 8'($urandom());
    wr(ssam_pkg::REG_SHIFT, own);
    wt(4);
    rv = 8'hFF;
    for (int i = 0; i < 2000 && rv[ssam_pkg::ST_BUSY]; i++) rd(ssam_pkg::REG_STATUS);
    if (rv[ssam_pkg::ST_BUSY] !== 1'b0) begin
      error_cnt++;
    end
    chk("clock high after transfer", 8'(clk_o), 8'h01);
    chk("last serial out bit", 8'(do_pin), 8'(own[0]));
    rd(ssam_pkg::REG_SHIFT);
    chk("master shift in", rv, ssam_pkg::ALL_ONES);
    wr(ssam_pkg::REG_MODE, 8'h08);
    wt(2);
    chk("slave clock released", 8'(clk_oe_n), 8'h01);
    $display("test master done");
    test_done();
  end
endmodule // tb_ssam_slave_address_match
